// ---- srtap_consts.vh ----
// constants for the memory test access port: widths, instruction codes, presets
// assumes inclusion by the port top module, its checker and its bench
`ifndef SRTAP_CONSTS_VH
`define SRTAP_CONSTS_VH

`define SRTAP_IR_W 3
`define SRTAP_ID_W 32
`define SRTAP_BSR_W 107
`define SRTAP_OE_BIT 47

`define SRTAP_IR_EXTEST 3'h0
`define SRTAP_IR_IDCODE 3'h1
`define SRTAP_IR_SAMPLEZ 3'h2
`define SRTAP_IR_PRELOAD 3'h4
`define SRTAP_IR_BYPASS 3'h7
`define SRTAP_IR_CAPTURE 3'h1
`define SRTAP_IR_RSVD3 3'h3
`define SRTAP_IR_RSVD5 3'h5
`define SRTAP_IR_RSVD6 3'h6

// identification value is arbitrary; bit 0 set marks the register as present
`define SRTAP_ID_VALUE 32'h0ABC_D001

// preload stage after reset: only the read bus enable cell is high
`define SRTAP_UPD_PRESET (107'h1 << 47)

`define SRTAP_SEL_BYPASS 2'h0
`define SRTAP_SEL_ID 2'h1
`define SRTAP_SEL_BSR 2'h2

`define SRTAP_FIFO_W 2
`define SRTAP_FIFO_DEPTH 8
`define SRTAP_FIFO_AW 3

`endif

// ---- srtap_sync.v ----
// two flip-flop synchroniser for a group of asynchronous levels
// assumes each bit is an independent level; no bus coherency is given
`timescale 1ns/1ps
module srtap_sync #(
    parameter WIDTH = 1
) (
    input wire clock,
    input wire rst,
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] stage1;
    reg [WIDTH-1:0] stage2;

    always @(posedge clock) begin
        if (rst) begin
            stage1 <= {WIDTH{1'b0}};
            stage2 <= {WIDTH{1'b0}};
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
        end
    end

    assign sync_out = stage2;
endmodule // srtap_sync

// ---- srtap_fifo.v ----
// small synchronous fifo with valid/ready on both sides
// assumes one clock; depth is a power of two given by ADDR_W
`timescale 1ns/1ps
module srtap_fifo #(
    parameter WIDTH = 2,
    parameter DEPTH = 8,
    parameter ADDR_W = 3
) (
    input wire clock,
    input wire rst,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [ADDR_W-1:0] wr_ptr;
    reg [ADDR_W-1:0] rd_ptr;
    reg [ADDR_W:0] count;
    wire push;
    wire pop;

    assign in_ready = (count != DEPTH[ADDR_W:0]);
    assign out_valid = (count != {(ADDR_W+1){1'b0}});
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign out_data = mem[rd_ptr];

    always @(posedge clock) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always @(posedge clock) begin
        if (rst) begin
            wr_ptr <= {ADDR_W{1'b0}};
            rd_ptr <= {ADDR_W{1'b0}};
            count <= {(ADDR_W+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push & ~pop) begin
                count <= count + 1'b1;
            end else if (pop & ~push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // srtap_fifo

// ---- srtap_top.v ----
// test access port of a synchronous memory: controller, instruction and data registers
// assumes the scan pins arrive asynchronously and are oversampled by clock (200 MHz)
// Notes on behaviour
// - capture fixed identification word in capture-dr
// - identification word shifts out during shift-dr
// - three-bit instruction, five codes implemented
// - instruction register sits in path during shift-ir
// - new instruction acts only at update-ir
// - identification instruction after reset or test-logic-reset
// - outputs-off capture uses boundary register path
// - outputs-off instruction floats read bus
// - sample/preload snapshots all pins at capture-dr
// - boundary register shifts out after capture
// - update-dr latches pattern into preload stage
// - shift in and out in one pass
// - bypass instruction puts one bit in path
// - external test drives preload values out
// - cell 47 governs read bus under extest
// - cell high drives bus, low floats
// - cell 47 preset high at reset
// - transitions decided by mode select at rise
// - instruction code decoding table
// - five high mode select edges reset controller
// - capture-ir loads 01 into low bits
// - sample on rise, change out on fall
`timescale 1ns/1ps
`include "srtap_consts.vh"
module srtap_top (
    input wire clock,
    input wire rst,
    input wire tck,
    input wire tms,
    input wire tdi,
    output reg tdo,
    output reg tdo_oe,
    input wire [`SRTAP_BSR_W-1:0] pin_snapshot,
    output reg [`SRTAP_BSR_W-1:0] boundary_out,
    output reg extest_drive,
    output reg read_bus_oe,
    output reg [`SRTAP_IR_W-1:0] ir_current,
    output reg [3:0] tap_state
);
    localparam ST_TLR = 4'h0;
    localparam ST_RTI = 4'h1;
    localparam ST_SELDR = 4'h2;
    localparam ST_CAPDR = 4'h3;
    localparam ST_SHDR = 4'h4;
    localparam ST_EX1DR = 4'h5;
    localparam ST_PADR = 4'h6;
    localparam ST_EX2DR = 4'h7;
    localparam ST_UPDR = 4'h8;
    localparam ST_SELIR = 4'h9;
    localparam ST_CAPIR = 4'hA;
    localparam ST_SHIR = 4'hB;
    localparam ST_EX1IR = 4'hC;
    localparam ST_PAIR = 4'hD;
    localparam ST_EX2IR = 4'hE;
    localparam ST_UPIR = 4'hF;

    // data register chosen by an instruction; reserved codes fall to bypass
    function [1:0] dr_select;
        input [`SRTAP_IR_W-1:0] code;
        begin
            case (code)
                `SRTAP_IR_EXTEST: dr_select = `SRTAP_SEL_BSR;
                `SRTAP_IR_SAMPLEZ: dr_select = `SRTAP_SEL_BSR;
                `SRTAP_IR_PRELOAD: dr_select = `SRTAP_SEL_BSR;
                `SRTAP_IR_IDCODE: dr_select = `SRTAP_SEL_ID;
                `SRTAP_IR_RSVD3: dr_select = `SRTAP_SEL_BYPASS;
                `SRTAP_IR_RSVD5: dr_select = `SRTAP_SEL_BYPASS;
                `SRTAP_IR_RSVD6: dr_select = `SRTAP_SEL_BYPASS;
                default: dr_select = `SRTAP_SEL_BYPASS;
            endcase
        end
    endfunction

    // controller transition on one sampled mode select level
    function [3:0] tap_next;
        input [3:0] s;
        input m;
        begin
            case (s)
                ST_TLR: tap_next = m ? ST_TLR : ST_RTI;
                ST_RTI: tap_next = m ? ST_SELDR : ST_RTI;
                ST_SELDR: tap_next = m ? ST_SELIR : ST_CAPDR;
                ST_CAPDR: tap_next = m ? ST_EX1DR : ST_SHDR;
                ST_SHDR: tap_next = m ? ST_EX1DR : ST_SHDR;
                ST_EX1DR: tap_next = m ? ST_UPDR : ST_PADR;
                ST_PADR: tap_next = m ? ST_EX2DR : ST_PADR;
                ST_EX2DR: tap_next = m ? ST_UPDR : ST_SHDR;
                ST_UPDR: tap_next = m ? ST_SELDR : ST_RTI;
                ST_SELIR: tap_next = m ? ST_TLR : ST_CAPIR;
                ST_CAPIR: tap_next = m ? ST_EX1IR : ST_SHIR;
                ST_SHIR: tap_next = m ? ST_EX1IR : ST_SHIR;
                ST_EX1IR: tap_next = m ? ST_UPIR : ST_PAIR;
                ST_PAIR: tap_next = m ? ST_EX2IR : ST_PAIR;
                ST_EX2IR: tap_next = m ? ST_UPIR : ST_SHIR;
                ST_UPIR: tap_next = m ? ST_SELDR : ST_RTI;
                default: tap_next = ST_TLR;
            endcase
        end
    endfunction

    // states in which a register sits between data in and data out
    function is_shift;
        input [3:0] s;
        begin
            is_shift = (s == ST_SHIR) | (s == ST_SHDR);
        end
    endfunction

    wire [2:0] scan_sync;
    wire [`SRTAP_BSR_W-1:0] pins_sync;
    wire tck_s;
    wire tms_s;
    wire tdi_s;
    reg tck_d;
    reg rise_pend;
    reg push_req;
    reg [`SRTAP_IR_W-1:0] ir_shift;
    reg [`SRTAP_ID_W-1:0] id_shift;
    reg bypass_bit;
    reg [`SRTAP_BSR_W-1:0] bsr_shift;
    reg [`SRTAP_BSR_W-1:0] bsr_update;
    wire tck_rise;
    wire tck_fall;
    wire step;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [`SRTAP_FIFO_W-1:0] fifo_out_data;
    wire [1:0] sel;
    wire [3:0] next_tap;
    reg next_read_bus_oe;
    reg next_out_bit;
    wire next_out_en;

    srtap_sync #(
        .WIDTH(3)
    ) u_scan_sync (
        .clock(clock),
        .rst(rst),
        .async_in({tck, tms, tdi}),
        .sync_out(scan_sync)
    );

    srtap_sync #(
        .WIDTH(`SRTAP_BSR_W)
    ) u_pin_sync (
        .clock(clock),
        .rst(rst),
        .async_in(pin_snapshot),
        .sync_out(pins_sync)
    );

    assign tck_s = scan_sync[2];
    assign tms_s = scan_sync[1];
    assign tdi_s = scan_sync[0];
    assign tck_rise = tck_s & ~tck_d;
    assign tck_fall = ~tck_s & tck_d;
    // a rise waits while the output queue is full or a push is still pending
    assign step = rise_pend & fifo_in_ready & ~push_req;
    assign sel = dr_select(ir_current);
    // five high mode select rises always end in the reset state
    assign next_tap = tap_next(tap_state, tms_s);

    always @(posedge clock) begin
        if (rst) begin
            tck_d <= 1'b0;
            rise_pend <= 1'b0;
        end else begin
            tck_d <= tck_s;
            if (tck_rise) begin
                rise_pend <= 1'b1;
            end else if (step) begin
                rise_pend <= 1'b0;
            end
        end
    end

    // controller and register actions, one per test clock rise
    always @(posedge clock) begin
        if (rst) begin
            tap_state <= ST_TLR;
            ir_current <= `SRTAP_IR_IDCODE;
            ir_shift <= `SRTAP_IR_CAPTURE;
            id_shift <= {`SRTAP_ID_W{1'b0}};
            bypass_bit <= 1'b0;
            bsr_shift <= {`SRTAP_BSR_W{1'b0}};
            bsr_update <= `SRTAP_UPD_PRESET;
        end else if (step) begin
            tap_state <= next_tap;
            case (tap_state)
                ST_CAPIR: begin
                    ir_shift <= `SRTAP_IR_CAPTURE;
                end
                ST_SHIR: begin
                    ir_shift <= {tdi_s, ir_shift[`SRTAP_IR_W-1:1]};
                end
                ST_UPIR: begin
                    ir_current <= ir_shift;
                end
                ST_CAPDR: begin
                    case (sel)
                        `SRTAP_SEL_ID: id_shift <= `SRTAP_ID_VALUE;
                        `SRTAP_SEL_BSR: bsr_shift <= pins_sync;
                        default: bypass_bit <= 1'b0;
                    endcase
                end
                ST_SHDR: begin
                    case (sel)
                        `SRTAP_SEL_ID: id_shift <= {tdi_s, id_shift[`SRTAP_ID_W-1:1]};
                        `SRTAP_SEL_BSR: bsr_shift <= {tdi_s, bsr_shift[`SRTAP_BSR_W-1:1]};
                        default: bypass_bit <= tdi_s;
                    endcase
                end
                ST_UPDR: begin
                    if (sel == `SRTAP_SEL_BSR) begin
                        bsr_update <= bsr_shift;
                    end
                end
                default: begin
                end
            endcase
            // entering the reset state restores instruction and preset at once
            if (next_tap == ST_TLR) begin
                ir_current <= `SRTAP_IR_IDCODE;
                bsr_update <= `SRTAP_UPD_PRESET;
            end
        end
    end

    // serial output bit of the register now in the path
    always @* begin
        next_out_bit = 1'b0;
        if (tap_state == ST_SHIR) begin
            next_out_bit = ir_shift[0];
        end else begin
            case (sel)
                `SRTAP_SEL_ID: next_out_bit = id_shift[0];
                `SRTAP_SEL_BSR: next_out_bit = bsr_shift[0];
                default: next_out_bit = bypass_bit;
            endcase
        end
    end

    assign next_out_en = is_shift(tap_state);

    // the bit decided after a rise is queued and shown at the next fall
    always @(posedge clock) begin
        if (rst) begin
            push_req <= 1'b0;
        end else if (step) begin
            push_req <= 1'b1;
        end else if (fifo_in_ready) begin
            push_req <= 1'b0;
        end
    end

    srtap_fifo #(
        .WIDTH(`SRTAP_FIFO_W),
        .DEPTH(`SRTAP_FIFO_DEPTH),
        .ADDR_W(`SRTAP_FIFO_AW)
    ) u_out_fifo (
        .clock(clock),
        .rst(rst),
        .in_valid(push_req),
        .in_ready(fifo_in_ready),
        .in_data({next_out_en, next_out_bit}),
        .out_valid(fifo_out_valid),
        .out_ready(tck_fall),
        .out_data(fifo_out_data)
    );

    always @(posedge clock) begin
        if (rst) begin
            tdo <= 1'b0;
            tdo_oe <= 1'b0;
        end else if (tck_fall & fifo_out_valid) begin
            tdo <= fifo_out_data[0];
            tdo_oe <= fifo_out_data[1];
        end
    end

    // read bus enable as each instruction asks for it
    always @* begin
        case (ir_current)
            `SRTAP_IR_SAMPLEZ: begin
                next_read_bus_oe = 1'b0;
            end
            `SRTAP_IR_EXTEST: begin
                next_read_bus_oe = bsr_update[`SRTAP_OE_BIT];
            end
            default: begin
                next_read_bus_oe = 1'b1;
            end
        endcase
    end

    // system side: pin drive under external test and read bus enable
    always @(posedge clock) begin
        if (rst) begin
            boundary_out <= `SRTAP_UPD_PRESET;
            extest_drive <= 1'b0;
            read_bus_oe <= 1'b1;
        end else begin
            boundary_out <= bsr_update;
            extest_drive <= (ir_current == `SRTAP_IR_EXTEST);
            read_bus_oe <= next_read_bus_oe;
        end
    end
endmodule // srtap_top

// ---- srtap_top_sva.sv ----
// assertions on the ports of the memory test access port
// assumes binding to srtap_top; a single clock domain with synchronous reset
`timescale 1ns/1ps
`include "srtap_consts.vh"
module srtap_sva (
    input wire logic clock,
    input wire logic rst,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe,
    input wire logic [`SRTAP_BSR_W-1:0] pin_snapshot,
    input wire logic [`SRTAP_BSR_W-1:0] boundary_out,
    input wire logic extest_drive,
    input wire logic read_bus_oe,
    input wire logic [`SRTAP_IR_W-1:0] ir_current,
    input wire logic [3:0] tap_state
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    property p_oe_shift; tdo_oe |-> tap_state inside {4'h4, 4'h5, 4'hB, 4'hC}; endproperty
    a_oe_shift: assert property (p_oe_shift) else $error("tdo driven outside shift");
    property p_tdo_low; $changed(tdo) || $changed(tdo_oe) |-> !tck; endproperty
    a_tdo_low: assert property (p_tdo_low) else $error("tdo moved while tck high");
    property p_ir_upd;
        $changed(ir_current) |-> $past(tap_state) == 4'hF || $past(tap_state, 2) == 4'hF || tap_state == 4'h0;
    endproperty
    a_ir_upd: assert property (p_ir_upd) else $error("instruction changed outside update");
    property p_tlr_id; tap_state == 4'h0 |-> ##[0:2] ir_current == `SRTAP_IR_IDCODE; endproperty
    a_tlr_id: assert property (p_tlr_id) else $error("reset state without id instruction");
    property p_tlr_preset; tap_state == 4'h0 |-> ##[0:2] boundary_out[`SRTAP_OE_BIT]; endproperty
    a_tlr_preset: assert property (p_tlr_preset) else $error("enable cell not preset");
    property p_bsr_upd; $changed(boundary_out) |-> tap_state inside {4'h0, 4'h1, 4'h2, 4'h8}; endproperty
    a_bsr_upd: assert property (p_bsr_upd) else $error("preload stage changed off update");
    property p_samplez; $past(ir_current, 2) == 3'h2 && ir_current == 3'h2 |-> !read_bus_oe; endproperty
    a_samplez: assert property (p_samplez) else $error("read bus driven under outputs off");
    property p_extest_oe;
        $past(ir_current, 2) == 3'h0 && ir_current == 3'h0 && $past(boundary_out[47], 2) == boundary_out[47]
            |-> read_bus_oe == boundary_out[47];
    endproperty
    a_extest_oe: assert property (p_extest_oe) else $error("read bus not following cell");
    property p_extest_flag; ir_current == $past(ir_current, 2) |-> extest_drive == (ir_current == 3'h0); endproperty
    a_extest_flag: assert property (p_extest_flag) else $error("extest drive wrong");
    property p_others_oe;
        ir_current inside {3'h1, 3'h4, 3'h7} && $past(ir_current, 2) == ir_current |-> read_bus_oe;
    endproperty
    a_others_oe: assert property (p_others_oe) else $error("read bus floated");
    property p_upd_next;
        $changed(tap_state) && $past(tap_state) inside {4'h8, 4'hF} |-> tap_state inside {4'h1, 4'h2};
    endproperty
    a_upd_next: assert property (p_upd_next) else $error("bad step after update");
    c_shift: cover property (tap_state == 4'h4 && tdo_oe);
    c_float: cover property (extest_drive && !read_bus_oe);
    c_samplez: cover property (ir_current == 3'h2);
endmodule // srtap_sva
bind srtap_top srtap_sva u_sva (.clock(clock), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe(tdo_oe), .pin_snapshot(pin_snapshot), .boundary_out(boundary_out), .extest_drive(extest_drive),
    .read_bus_oe(read_bus_oe), .ir_current(ir_current), .tap_state(tap_state));

// ---- srtap_master.sv ----
// scan master model: drives test clock, mode select and data in, reads data out
// assumes a 48 ns test clock that stands low between operations
`timescale 1ns/1ps
module srtap_master (
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe
);
    logic oe_all;
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
        oe_all = 1'b1;
    end
    // data out is read mid high phase, where it stands until the next fall
    task step(input logic m, input logic d, output logic q, output logic o);
        tms = m;
        tdi = d;
        #24 tck = 1'b1;
        #12 q = tdo;
        o = tdo_oe;
        #12 tck = 1'b0;
    endtask
    task shift(input logic ir, input int n, input logic [127:0] din, output logic [127:0] dout);
        logic q;
        logic o;
        dout = '0;
        oe_all = 1'b1;
        if (ir) step(1'b1, 1'b1, q, o);
        step(1'b1, 1'b1, q, o);
        step(1'b0, 1'b1, q, o);
        step(1'b0, 1'b1, q, o);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q, o);
            dout[i] = q;
            oe_all = oe_all & o;
        end
        step(1'b1, 1'b1, q, o);
        step(1'b0, 1'b1, q, o);
    endtask
endmodule // srtap_master

// ---- srtap_top_tb.sv ----
// self-checking bench for the memory test access port
// assumes srtap_top with its fifo and synchroniser, the scan master model and the checker
`timescale 1ns/1ps
`include "srtap_consts.vh"
module srtap_top_tb;
    localparam logic [`SRTAP_BSR_W-1:0] PINS = 107'h6_1234_5678_9ABC_DEF0_1357_2468;
    localparam logic [`SRTAP_BSR_W-1:0] PRE = 107'h2_8765_4321_0FED_4BA9_8642_1357;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [`SRTAP_BSR_W-1:0] pin_snapshot = PINS;
    wire tck, tms, tdi, tdo, tdo_oe, extest_drive, read_bus_oe;
    wire [`SRTAP_BSR_W-1:0] boundary_out;
    wire [`SRTAP_IR_W-1:0] ir_current;
    wire [3:0] tap_state;
    logic [127:0] dout;
    logic q, o;
    int fail_count = 0;
    int checked = 0;
    always #2.5 clock = ~clock;
    srtap_top dut (.clock(clock), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
        .pin_snapshot(pin_snapshot), .boundary_out(boundary_out), .extest_drive(extest_drive),
        .read_bus_oe(read_bus_oe), .ir_current(ir_current), .tap_state(tap_state));
    srtap_master m (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));
    task chk(input logic [127:0] got, input logic [127:0] exp, input string msg);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: %s got %0h exp %0h", $time, msg, got, exp);
        end
    endtask
    // implemented codes only are loaded
    task ld(input logic [2:0] c);
        m.shift(1'b1, 3, {125'h0, c}, dout);
        chk(dout[1:0], 2'b01, "ir capture");
        chk(ir_current, c, "ir loaded");
        chk(m.oe_all, 1'b1, "oe in shift ir");
    endtask
    task t_reset;
        chk(ir_current, `SRTAP_IR_IDCODE, "ir after reset");
        chk(boundary_out, `SRTAP_UPD_PRESET, "preset");
        chk(read_bus_oe, 1'b1, "bus on");
        chk(tdo_oe, 1'b0, "tdo float");
        m.step(1'b0, 1'b1, q, o);
    endtask
    task t_id;
        m.shift(1'b0, 32, 128'h0, dout);
        chk(dout[31:0], `SRTAP_ID_VALUE, "id");
        chk(m.oe_all, 1'b1, "oe in shift dr");
    endtask
    task t_bypass;
        ld(`SRTAP_IR_BYPASS);
        m.shift(1'b0, 8, 128'hA5, dout);
        chk(dout[7:0], 8'h4A, "bypass");
    endtask
    task t_sample;
        ld(`SRTAP_IR_PRELOAD);
        m.shift(1'b0, `SRTAP_BSR_W, PRE, dout);
        chk(dout[106:0], PINS, "sample");
        chk(boundary_out, PRE, "preload");
        chk(read_bus_oe, 1'b1, "sample keeps bus");
    endtask
    task t_extest;
        ld(`SRTAP_IR_EXTEST);
        chk(extest_drive, 1'b1, "extest drive");
        chk(read_bus_oe, 1'b0, "cell low floats");
        m.shift(1'b0, `SRTAP_BSR_W, PRE | `SRTAP_UPD_PRESET, dout);
        chk(dout[106:0], PINS, "extest path");
        chk(read_bus_oe, 1'b1, "cell high drives");
    endtask
    task t_samplez;
        ld(`SRTAP_IR_SAMPLEZ);
        chk(read_bus_oe, 1'b0, "outputs off");
        m.shift(1'b0, `SRTAP_BSR_W, PINS, dout);
        chk(dout[106:0], PINS, "outputs off path");
        chk(read_bus_oe, 1'b0, "still off");
        t_bypass;
        chk(read_bus_oe, 1'b1, "bus back");
    endtask
    task t_reset5;
        ld(`SRTAP_IR_EXTEST);
        repeat (5) m.step(1'b1, 1'b1, q, o);
        chk(tap_state, 4'h0, "five high edges");
        repeat (4) @(negedge clock);
        t_reset;
        t_id;
    endtask
    task summarize;
        $display("checked %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (4) @(negedge clock);
        rst = 1'b0;
        repeat (4) @(negedge clock);
        t_reset;
        t_id;
        t_bypass;
        t_sample;
        t_extest;
        t_samplez;
        t_reset5;
        summarize;
    end
    initial begin
        #100000;
        fail_count++;
        summarize;
    end
endmodule // srtap_top_tb
